// *** core/dpr_pkg.sv ***
/*
  Shared constants and types for the synchronous dual-port RAM port control.
  Assumes one port clock; the memory holds one word per address.
*/
package dpr_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int DPR_ADDR_W = 14;  // Address width, one word per location.
  localparam int DPR_DATA_W = 16;  // Data word width.
  localparam int DPR_LANE_W = 8;   // Width of one byte lane.
  localparam int DPR_LANES  = 2;   // Byte lanes in a word.
  localparam int DPR_DEPTH  = 16384;  // Number of words.
  localparam int DPR_LANE_HI = 1;  // Index of the upper byte lane.
  localparam int DPR_LANE_LO = 0;  // Index of the lower byte lane.

  // ****************************************
  // Reset and counter values
  // ****************************************
  localparam logic [DPR_ADDR_W-1:0] DPR_ADDR_ZERO = 14'h0000;  // Counter clear value.
  localparam logic [DPR_ADDR_W-1:0] DPR_ADDR_ONE  = 14'h0001;  // Counter step.
  localparam logic [DPR_DATA_W-1:0] DPR_DATA_ZERO = 16'h0000;  // Data reset value.
  localparam logic [DPR_LANES-1:0]  DPR_LANES_OFF = 2'h0;      // No lane driven.

  // ****************************************
  // Counter operations
  // ****************************************
  typedef enum logic [1:0] {
    DPR_CNT_CLEAR,   // Go to address zero.
    DPR_CNT_LOAD,    // Take the external address.
    DPR_CNT_HOLD,    // Keep the previous address.
    DPR_CNT_STEP     // Advance by one, wrapping at the top.
  } dpr_cnt_op_type;

endpackage

// *** core/dpr_mem.sv ***
/*
  Word memory with per-lane write enables and a registered read port.
  Assumes the caller presents address, write lanes and data for one edge.
*/
`timescale 1ns/1ps

module dpr_mem
  import dpr_pkg::*;
(
  input  wire logic                  clk,      // Port clock.
  input  wire logic                  rst,      // Asynchronous reset, active high.
  input  wire logic [DPR_ADDR_W-1:0] addr,     // Access address.
  input  wire logic [DPR_LANES-1:0]  wr_lane,  // Write enable per byte lane.
  input  wire logic [DPR_DATA_W-1:0] wr_data,  // Write data.
  output logic      [DPR_DATA_W-1:0] rd_data   // Read data, registered.
);

  logic [DPR_DATA_W-1:0] store [DPR_DEPTH];  // Memory array.
  logic [DPR_DATA_W-1:0] next_rd_data;       // Word read this cycle.

  // ****************************************
  // Array write and read
  // ****************************************

  // Lanes are written independently; the array itself has no reset.
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < DPR_LANES; i++)
    begin
      if (wr_lane[i])
      begin
        store[addr][i*DPR_LANE_W +: DPR_LANE_W] <= wr_data[i*DPR_LANE_W +: DPR_LANE_W];
      end
    end
  end

  // The read returns the old word when the same edge also writes it.
  always_comb
  begin
    next_rd_data = store[addr];
  end

  // Read data register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data <= DPR_DATA_ZERO;
    end
    else
    begin
      rd_data <= next_rd_data;
    end
  end

endmodule // dpr_mem

// *** core/dpr_port_ctrl.sv ***
/*
  One port of a synchronous dual-port static RAM: chip selects, read and
  write steering, byte lanes, burst address counter, flow-through or
  pipelined output and asynchronous output enable.
  Assumes all inputs except output_enable_n are synchronous to clk and
  that pipe_mode is held steady while the port is in use.
*/
`timescale 1ns/1ps

// Overview of operation
// R1 - Inputs except output enable sampled on rising clock.
// R2 - Output enable high releases data pins immediately.
// R3 - Deselect tristates data after the next edge.
// R4 - Pipelined: chip select change acts one clock later.
// R5 - Selected with read low writes, read high drives.
// R6 - Counter clear low forces address zero, highest priority.
// R7 - Strobe low loads external address into counter.
// R8 - Strobe, advance, clear high: counter holds address.
// R9 - Advance low with strobe high: counter steps.
// R10 - Access address is external or counter by strobe.
// R11 - Counter clear inserts no idle cycle.
// R12 - Counter works regardless of chip selects.
// R13 - Pipelined read data one clock after flow-through.
// R14 - Pipelined pin state set by previous cycle controls.
// R15 - Host rewrites location after a no-operation cycle.
// R16 - Strobe held low loads a fresh address each edge.
// R17 - Byte selects gate each lane's write and drive.
// R18 - Counter wraps from top address to zero.
module dpr_port_ctrl
  import dpr_pkg::*;
(
  input  wire logic                  clk,                      // Port clock.
  input  wire logic                  rst,                      // Async reset, high.
  input  wire logic                  pipe_mode,                // 1 pipelined, 0 flow.
  input  wire logic                  chip_select_low_active,   // Select, active low.
  input  wire logic                  chip_select_high_active,  // Select, active high.
  input  wire logic                  read_not_write,           // 1 read, 0 write.
  input  wire logic                  output_enable_n,          // Async output enable.
  input  wire logic                  upper_byte_select_n,      // Upper lane select.
  input  wire logic                  lower_byte_select_n,      // Lower lane select.
  input  wire logic                  address_strobe_n,         // Load address, low.
  input  wire logic                  count_advance_n,          // Step counter, low.
  input  wire logic                  counter_clear_n,          // Clear counter, low.
  input  wire logic [DPR_ADDR_W-1:0] address,                  // External address.
  input  wire logic [DPR_DATA_W-1:0] data_in,                  // Data pin input.
  output logic      [DPR_DATA_W-1:0] data_out,                 // Data pin output.
  output logic      [DPR_LANES-1:0]  data_oe,                  // Drive per lane.
  output logic      [DPR_ADDR_W-1:0] access_address            // Counter value.
);

  // ****************************************
  // Declarations
  // ****************************************
  dpr_cnt_op_type            cnt_op;          // Counter operation this edge.
  logic [DPR_ADDR_W-1:0]     count;           // Burst address counter.
  logic [DPR_ADDR_W-1:0]     next_count;      // Address used at this edge.
  logic                      selected;        // Both chip selects active.
  logic [DPR_LANES-1:0]      lane_n;          // Byte selects, active low.
  logic [DPR_LANES-1:0]      wr_lane;         // Lanes written this edge.
  logic [DPR_LANES-1:0]      rd_lane;         // Lanes read this edge.
  logic [DPR_LANES-1:0]      drive_flow;      // Lane drive, flow-through stage.
  logic [DPR_LANES-1:0]      next_drive_flow; // Next flow-through drive.
  logic [DPR_LANES-1:0]      drive_pipe;      // Lane drive, pipelined stage.
  logic [DPR_LANES-1:0]      next_drive_pipe; // Next pipelined drive.
  logic [DPR_DATA_W-1:0]     rd_data;         // Registered memory read.
  logic [DPR_DATA_W-1:0]     pipe_data;       // Extra pipeline data register.
  logic [DPR_DATA_W-1:0]     next_pipe_data;  // Next pipeline data.
  logic [DPR_LANES-1:0]      drive_sel;       // Drive chosen by mode.

  // ****************************************
  // Helper functions
  // ****************************************

  // Lanes taking part in an access of the given direction.
  function automatic logic [DPR_LANES-1:0] lane_mask
  (
    input logic                 sel,
    input logic                 want,
    input logic [DPR_LANES-1:0] sel_n
  );
    lane_mask = (sel && want) ? ~sel_n : DPR_LANES_OFF;
  endfunction

  // ****************************************
  // Address counter
  // ****************************************

  // Decode the counter operation; clear outranks load, load outranks step.
  // Chip selects play no part here.
  always_comb
  begin
    if (!counter_clear_n)
    begin
      cnt_op = DPR_CNT_CLEAR;  // R6 R12
    end
    else if (!address_strobe_n)
    begin
      cnt_op = DPR_CNT_LOAD;   // R7 R16
    end
    else if (!count_advance_n)
    begin
      cnt_op = DPR_CNT_STEP;   // R9
    end
    else
    begin
      cnt_op = DPR_CNT_HOLD;   // R8
    end
  end

  // Compute the address this edge accesses; it is also the counter's next value,
  // so a clear or load is accessed in the same cycle with no dead cycle.
  always_comb
  begin
    unique case (cnt_op)
      DPR_CNT_CLEAR: next_count = DPR_ADDR_ZERO;  // R6 R11
      DPR_CNT_LOAD:  next_count = address;        // R7 R10
      DPR_CNT_HOLD:  next_count = count;          // R8 R10
      DPR_CNT_STEP:  next_count = count + DPR_ADDR_ONE;  // R9 R18
    endcase
  end

  // Counter register, sampled on the rising edge only.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count <= DPR_ADDR_ZERO;
    end
    else
    begin
      count <= next_count;  // R1
    end
  end

  assign access_address = count;

  // ****************************************
  // Access decode and memory
  // ****************************************

  // Both chip selects must be active for a read or a write.
  always_comb
  begin
    selected = !chip_select_low_active && chip_select_high_active;          // R3
    lane_n   = {upper_byte_select_n, lower_byte_select_n};
    wr_lane  = lane_mask(selected, !read_not_write, lane_n);                // R5 R17
    rd_lane  = lane_mask(selected, read_not_write, lane_n);                 // R5 R17
  end

  // Word storage with a registered read port.
  dpr_mem u_mem
  (
    .clk     (clk),
    .rst     (rst),
    .addr    (next_count),
    .wr_lane (wr_lane),
    .wr_data (data_in),
    .rd_data (rd_data)
  );

  // ****************************************
  // Output pipeline
  // ****************************************

  // Flow-through drive follows the last edge's controls; the pipelined
  // stage lags one more clock, so a select change shows a clock later.
  always_comb
  begin
    next_drive_flow = rd_lane;     // R3 R14
    next_drive_pipe = drive_flow;  // R4 R14
    next_pipe_data  = rd_data;     // R13
  end

  // Output stage registers.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      drive_flow <= DPR_LANES_OFF;
      drive_pipe <= DPR_LANES_OFF;
      pipe_data  <= DPR_DATA_ZERO;
    end
    else
    begin
      drive_flow <= next_drive_flow;
      drive_pipe <= next_drive_pipe;
      pipe_data  <= next_pipe_data;
    end
  end

  // ****************************************
  // Data pins
  // ****************************************

  // Choose the stage by mode; both sources are flip-flops.
  always_comb
  begin
    if (pipe_mode)
    begin
      drive_sel = drive_pipe;  // R13
      data_out  = pipe_data;   // R13
    end
    else
    begin
      drive_sel = drive_flow;
      data_out  = rd_data;
    end
  end

  // Output enable gates the drive with no clock in the path.
  always_comb
  begin
    data_oe = output_enable_n ? DPR_LANES_OFF : drive_sel;  // R2
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Counter behaviour as seen on the observation port, one clock after the edge.
  property p_clear;
    !counter_clear_n |=> access_address == DPR_ADDR_ZERO;
  endproperty
  a_clear: assert property (p_clear)  // R6
    else $error("counter clear did not reach zero");

  property p_load;
    counter_clear_n && !address_strobe_n |=> access_address == $past(address);
  endproperty
  a_load: assert property (p_load)  // R7
    else $error("counter did not load address");

  property p_hold;
    counter_clear_n && address_strobe_n && count_advance_n |=> $stable(access_address);
  endproperty
  a_hold: assert property (p_hold)  // R8
    else $error("counter did not hold");

  property p_step;
    counter_clear_n && address_strobe_n && !count_advance_n
      |=> access_address == $past(access_address) + DPR_ADDR_ONE;
  endproperty
  a_step: assert property (p_step)  // R9
    else $error("counter did not step by one");

  // The address handed to the array at the same edge; a lag here is a dead cycle.
  property p_clear_access;
    !counter_clear_n |-> next_count == DPR_ADDR_ZERO;
  endproperty
  a_clear_access: assert property (p_clear_access)  // R11
    else $error("cleared address not accessed at once");

  property p_addr_load;
    counter_clear_n && !address_strobe_n |-> next_count == address;
  endproperty
  a_addr_load: assert property (p_addr_load)  // R10
    else $error("strobe low did not access external address");

  property p_addr_hold;
    counter_clear_n && address_strobe_n && count_advance_n |-> next_count == access_address;
  endproperty
  a_addr_hold: assert property (p_addr_hold)  // R10
    else $error("strobe high did not access counter address");

  // Write steering from the pins, lane by lane.
  property p_write_lanes;
    !chip_select_low_active && chip_select_high_active && !read_not_write
      |-> wr_lane == ~{upper_byte_select_n, lower_byte_select_n};
  endproperty
  a_write_lanes: assert property (p_write_lanes)  // R17
    else $error("selected write did not follow byte selects");

  property p_desel_no_write;
    chip_select_low_active || !chip_select_high_active |-> wr_lane == DPR_LANES_OFF;
  endproperty
  a_desel_no_write: assert property (p_desel_no_write)  // R5
    else $error("deselected port wrote the array");

  // Pin drive in both output modes.
  property p_oe_off;
    output_enable_n |-> data_oe == DPR_LANES_OFF;
  endproperty
  a_oe_off: assert property (p_oe_off)  // R2
    else $error("pins driven with output enable off");

  property p_flow_read;
    !pipe_mode && !chip_select_low_active && chip_select_high_active && read_not_write
      ##1 !pipe_mode && !output_enable_n |-> data_oe == ~$past(lane_n);
  endproperty
  a_flow_read: assert property (p_flow_read)  // R5
    else $error("flow read did not drive the selected lanes");

  property p_write_quiet;
    !pipe_mode && !read_not_write ##1 !pipe_mode |-> data_oe == DPR_LANES_OFF;
  endproperty
  a_write_quiet: assert property (p_write_quiet)  // R5
    else $error("pins driven after a write");

  property p_flow_desel;
    !pipe_mode && !selected ##1 !pipe_mode |-> data_oe == DPR_LANES_OFF;
  endproperty
  a_flow_desel: assert property (p_flow_desel)  // R3
    else $error("flow deselect still drives");

  property p_pipe_desel;
    pipe_mode && !selected ##1 pipe_mode[*2] |-> data_oe == DPR_LANES_OFF;
  endproperty
  a_pipe_desel: assert property (p_pipe_desel)  // R4
    else $error("pipelined deselect still drives");

  property p_pipe_read;
    pipe_mode && !output_enable_n && rd_lane == ~lane_n ##1 pipe_mode ##1
      pipe_mode && !output_enable_n |-> data_oe == $past(rd_lane, 2);
  endproperty
  a_pipe_read: assert property (p_pipe_read)  // R14
    else $error("pipelined drive not from prior controls");

  property p_pipe_data;
    pipe_mode ##1 pipe_mode |-> data_out == $past(rd_data);
  endproperty
  a_pipe_data: assert property (p_pipe_data)  // R13
    else $error("pipelined data not one clock late");

endmodule // dpr_port_ctrl

// *** testbench/dpr_host_pins.sv ***
/*
  Host-side pin model for one RAM port: resolves the shared data pins.
  Assumes one port clock; a lane nobody drives shows the inverse of its last level.
*/
`timescale 1ns/1ps

module dpr_host_pins
  import dpr_pkg::*;
(
  input  wire logic                  clk,         // Port clock.
  input  wire logic [DPR_DATA_W-1:0] data_out,    // Device drive value.
  input  wire logic [DPR_LANES-1:0]  data_oe,     // Device drive per lane.
  input  wire logic [DPR_DATA_W-1:0] host_data,   // Host write data.
  input  wire logic                  host_drive,  // Host drives the pins.
  output logic      [DPR_DATA_W-1:0] pin          // Resolved pin level.
);
  localparam int W = DPR_LANE_W;  // Lane width shorthand.
  logic [DPR_DATA_W-1:0] last;    // Pin level at the previous edge.

  // ****************************************
  // Pin resolution
  // ****************************************
  // A floating lane flips at each edge, so it differs from the previous edge's level but repeats the level of two edges back.
  always_comb
  begin
    for (int i = 0; i < DPR_LANES; i++)
    begin
      if (data_oe[i])
        pin[i*W +: W] = data_out[i*W +: W];
      else if (host_drive)
        pin[i*W +: W] = host_data[i*W +: W];
      else
        pin[i*W +: W] = ~last[i*W +: W];
    end
  end

  // Remembers the level so a released lane can flip it.
  always_ff @(posedge clk)
  begin
    last <= pin;
  end
endmodule  // dpr_host_pins

// *** testbench/testbench.sv ***
/*
  Self-checking bench for one port: writes, reads, counter and output modes.
  Assumes the host model resolves the data pins and feeds them back as data_in.
*/
`timescale 1ns/1ps

module testbench;
  import dpr_pkg::*;
  logic                  clk, rst, pipe_mode, csl, csh, rnw, oe_n, ub_n, lb_n;  // Controls.
  logic                  ads_n, cnt_n, clr_n, drv;  // Counter controls, host drive.
  logic [DPR_ADDR_W-1:0] addr;                      // External address.
  logic [DPR_DATA_W-1:0] hdata, data_in, data_out, pin;  // Data paths.
  logic [DPR_LANES-1:0]  data_oe;                   // Lane drive.
  logic [DPR_ADDR_W-1:0] access_address;            // Counter view.
  int                    n_errors, checks_done;     // Tallies.
  logic [DPR_ADDR_W-1:0] tbl [4] = '{14'h0005, 14'h0006, 14'h3fff, 14'h0000};  // Test places.

  dpr_port_ctrl uut (.clk(clk), .rst(rst), .pipe_mode(pipe_mode),
    .chip_select_low_active(csl), .chip_select_high_active(csh), .read_not_write(rnw),
    .output_enable_n(oe_n), .upper_byte_select_n(ub_n), .lower_byte_select_n(lb_n),
    .address_strobe_n(ads_n), .count_advance_n(cnt_n), .counter_clear_n(clr_n),
    .address(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .access_address(access_address));
  dpr_host_pins host (.clk(clk), .data_out(data_out), .data_oe(data_oe),
    .host_data(hdata), .host_drive(drv), .pin(pin));
  assign data_in = pin;  // The device sees the resolved pins.

  // Clock at 200 MHz.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pattern stored at each address.
  function automatic logic [15:0] word(input logic [13:0] a);
    return {2'h0, a} ^ 16'ha5c3;
  endfunction

  // Compares a value and counts the result.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Presents one cycle of controls, then lets the edge land.
  task automatic cyc(input logic s0, s1, r, u, l, ad, cn, cl, input logic [13:0] a,
                     input logic [15:0] d, input logic dr);
    {csl, csh, rnw, ub_n, lb_n, ads_n, cnt_n, clr_n} = {s0, s1, r, u, l, ad, cn, cl};
    addr = a;
    hdata = d;
    drv = dr;
    @(posedge clk);
    #1;
  endtask

  // Selected write with an address load.
  task automatic wr(input logic [13:0] a, input logic [15:0] d, input logic u, l);
    cyc(0, 1, 0, u, l, 0, 1, 1, a, d, 1);
  endtask

  // Selected read with an address load.
  task automatic rd(input logic [13:0] a, input logic l);
    cyc(0, 1, 1, 0, l, 0, 1, 1, a, 16'h0000, 0);
  endtask

  // Prints the verdict and ends the run.
  task automatic close_out;
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    #20000;
    n_errors++;
    close_out();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    n_errors = 0;
    checks_done = 0;
    {rst, pipe_mode, oe_n, drv} = 4'h8;
    {csl, csh, rnw, ub_n, lb_n, ads_n, cnt_n, clr_n} = 8'hbf;
    addr = 14'h0000;
    hdata = 16'h0000;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    chk(data_oe, 2'h0);
    chk(access_address, 14'h0000);
    // Back-to-back writes, a fresh address every edge.
    foreach (tbl[i])
    begin
      wr(tbl[i], word(tbl[i]), 0, 0);
      chk(data_oe, 2'h0);
      chk(access_address, tbl[i]);
    end
    foreach (tbl[i])
    begin
      rd(tbl[i], 0);
      chk(pin, word(tbl[i]));
      chk(data_oe, 2'h3);
    end
    // Counter step, hold, wrap and clear.
    cyc(0, 1, 1, 0, 0, 1, 0, 1, 14'h0100, 0, 0);
    chk(access_address, 14'h0001);
    chk(data_oe, 2'h3);
    rd(14'h0005, 0);
    cyc(0, 1, 1, 0, 0, 1, 0, 1, 14'h0100, 0, 0);
    chk(access_address, 14'h0006);
    chk(pin, word(14'h0006));
    cyc(0, 1, 1, 0, 0, 1, 1, 1, 14'h0100, 0, 0);
    chk(access_address, 14'h0006);
    chk(pin, word(14'h0006));
    rd(14'h3fff, 0);
    cyc(0, 1, 1, 0, 0, 1, 0, 1, 14'h0100, 0, 0);
    chk(access_address, 14'h0000);
    chk(pin, word(14'h0000));
    cyc(0, 1, 1, 0, 0, 0, 0, 0, 14'h0005, 0, 0);
    chk(access_address, 14'h0000);
    chk(pin, word(14'h0000));
    cyc(1, 1, 1, 0, 0, 1, 0, 1, 14'h0100, 0, 0);
    chk(access_address, 14'h0001);
    chk(data_oe, 2'h0);
    cyc(0, 0, 1, 0, 0, 0, 1, 1, 14'h0005, 0, 0);
    chk(data_oe, 2'h0);
    // Output enable acts with no clock.
    rd(14'h0005, 0);
    oe_n = 1'b1;
    #1 chk(data_oe, 2'h0);
    oe_n = 1'b0;
    #1 chk(data_oe, 2'h3);
    // Byte lanes, after a turnaround cycle so the device has let go of the pins.
    cyc(1, 0, 1, 0, 0, 1, 1, 1, 14'h0000, 16'h0000, 0);
    chk(data_oe, 2'h0);
    wr(14'h0006, 16'hffff, 0, 1);
    rd(14'h0006, 1);
    chk(data_oe, 2'h2);
    rd(14'h0006, 0);
    chk(pin, 16'hff00 | (word(14'h0006) & 16'h00ff));
    // Pipelined reads land one cycle later.
    cyc(1, 0, 1, 0, 0, 1, 1, 1, 0, 0, 0);
    pipe_mode = 1'b1;
    cyc(1, 0, 1, 0, 0, 1, 1, 1, 0, 0, 0);
    rd(14'h0005, 0);
    chk(data_oe, 2'h0);
    cyc(1, 0, 1, 0, 0, 1, 1, 1, 0, 0, 0);
    chk(data_oe, 2'h3);
    chk(pin, word(14'h0005));
    cyc(1, 0, 1, 0, 0, 1, 1, 1, 0, 0, 0);
    chk(data_oe, 2'h0);
    close_out();
  end
endmodule  // testbench
